// >>> hw/dum_core.sv
// Control core: monitor select, reset, clear, busy and load-strobe update.
//
// Operation
// - Monitor command is SFR address 001010.
// - Enabled probing turns channel 39 into probe.
// - Address 0-38 routes that channel; rest undefined.
// - Address 63 three-states the probe output.
// - Reset starts on reset pin fall or soft reset command.
// - Reset: gain full, offset zero, data cleared.
// - Busy low for 270 us of reset.
// - Reset busy disables interfaces, drops strobes.
// - After reset, pin level ignored until fall.
// - Clear pin loads all data from clear code.
// - Clear completes within 35 us.
// - Register write recomputes word, busy low.
// - Writes accepted during calculation, no updates.
// - Strobe during calculation busy stored, applied at rise.
// - Strobe tied low updates after each calculation busy rise.
// - Busy low during power-on reset too.
// - Strobe updates only channels written since last.
// - SFR decoded only when both selects zero.
// - Control bit 7 enables probing, default off.
// - Soft clear behaves like clear pin.
`default_nettype none
module dum_core
  import dum_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_CYC,
  parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reset_pin_b_i,
  input wire logic clear_pin_b_i,
  input wire logic load_strobe_b_i,
  input wire logic cmd_valid_i,
  input wire logic register_select_hi_i,
  input wire logic register_select_lo_i,
  input wire logic [5:0] cmd_addr_i,
  input wire logic [11:0] cmd_data_i,
  output logic busy_b_o,
  output logic cmd_ready_o,
  output logic dac_we_o,
  output logic [5:0] dac_ch_o,
  output logic [11:0] dac_word_o,
  output logic probe_route_o,
  output logic [5:0] probe_channel_o,
  output logic probe_oe_o,
  output logic ch39_is_probe_o,
  output logic [11:0] ctrl_o
);
  // Three-stage synchronisers for the three pins; stages two and three feed the edge decode.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      sync3_reg <= 3'h7;
    end else begin
      sync1_reg <= {load_strobe_b_i, clear_pin_b_i, reset_pin_b_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Edge and level decode on the synchronised pins.
  // Reset acts on the pin fall only.
  wire reset_fall = sync3_reg[0] & ~sync2_reg[0];
  wire clear_fall = sync3_reg[1] & ~sync2_reg[1];
  wire strobe_fall = sync3_reg[2] & ~sync2_reg[2];
  wire strobe_low = ~sync2_reg[2];

  // Sequencer state and counters.
  dum_state_t state_reg, state_next;
  logic [15:0] cnt_reg;
  logic [5:0] ch_reg;
  logic strobe_pend_reg;
  logic [NUM_CH-1:0] dirty_reg;
  logic [11:0] clr_code_reg;
  logic [11:0] gain_q [NUM_CH];
  logic [11:0] offs_q [NUM_CH];

  // Command decode; SFR only with both selects low.
  wire [1:0] sel = {register_select_hi_i, register_select_lo_i};
  wire accept = cmd_valid_i & cmd_ready_o;
  wire is_sfr = accept & (sel == SEL_SFR);
  wire is_mon = is_sfr & (cmd_addr_i == SFR_MONITOR);
  wire is_ctrl = is_sfr & (cmd_addr_i == SFR_CTRL);
  wire is_clrc = is_sfr & (cmd_addr_i == SFR_CLR_CODE);
  // Soft clear merged with pin clear.
  wire do_clear = clear_fall | (is_sfr & (cmd_addr_i == SFR_SOFT_CLR));
  wire do_reset = reset_fall | (is_sfr & (cmd_addr_i == SFR_SOFT_RST));
  wire chan_ok = cmd_addr_i < 6'(NUM_CH);
  wire is_wr = accept & (sel != SEL_SFR) & chan_ok;
  wire [5:0] cnt_ch = cnt_reg[5:0];
  wire scan_done = cnt_ch == 6'(NUM_CH - 1);

  // Input data memory: holds the raw words that feed the correction.
  logic [11:0] x1_rd;
  dum_word_mem #(
    .DEPTH(NUM_CH),
    .WIDTH(DATA_W),
    .AW(CH_W)
  ) u_x1 (
    .clk_i(clk_i),
    .we_i(is_wr & (sel == SEL_DATA)),
    .waddr_i(cmd_addr_i),
    .wdata_i(cmd_data_i),
    .raddr_i(ch_reg),
    .rdata_o(x1_rd)
  );

  // Gain and offset registers, restored by reset.
  // Gain full scale, offset zero.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        gain_q[i] <= GAIN_RST;
        offs_q[i] <= OFFS_RST;
      end
    end else if (state_reg == DUM_RESET) begin
      for (int i = 0; i < NUM_CH; i++) begin
        gain_q[i] <= GAIN_RST;
        offs_q[i] <= OFFS_RST;
      end
    end else if (is_wr && sel == SEL_GAIN) begin
      gain_q[cmd_addr_i] <= cmd_data_i;
    end else if (is_wr && sel == SEL_OFFS) begin
      offs_q[cmd_addr_i] <= cmd_data_i;
    end
  end

  // Corrected word: x1*(m+2)/4096 + c - 2048, clipped to 12 bits.
  wire [25:0] prod = 26'(x1_rd) * 26'({gain_q[ch_reg]} + 13'h2);
  wire signed [14:0] sum = 15'(prod[25:12]) + 15'(offs_q[ch_reg])
                           - 15'h0800;
  wire [11:0] corr = sum < 0 ? 12'h000 :
                     (sum > 15'sh0FFF ? 12'hFFF : sum[11:0]);

  // Corrected word memory written by the calculation engine.
  logic [11:0] x2_q [NUM_CH];
  logic calc_we;
  logic [5:0] calc_ch_reg;
  logic calc_ph_reg;
  // One bit per channel whose corrected word still has to be computed.
  logic [NUM_CH-1:0] pend_reg;
  // Next channel of the calculation walk, wrapping after the last one.
  wire [5:0] ch_next = (ch_reg == 6'(NUM_CH - 1)) ? 6'h00 : ch_reg + 6'h01;
  always_ff @(posedge clk_i) begin
    if (calc_we) begin
      x2_q[calc_ch_reg] <= corr;
    end
  end

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DUM_IDLE: begin
        if (do_reset) begin
          state_next = DUM_RESET;
        end else if (do_clear) begin
          state_next = DUM_CLEAR;
        end else if (is_wr || pend_reg != '0) begin
          state_next = DUM_CALC;
        end
      end
      DUM_CALC: begin
        if (do_reset) begin
          state_next = DUM_RESET;
        end else if (do_clear) begin
          state_next = DUM_CLEAR;
        end else if (pend_reg == '0 && !calc_we
                     && cnt_reg >= 16'(CALC_CYC) && !is_wr) begin
          state_next = DUM_IDLE;
        end
      end
      DUM_CLEAR: begin
        if (do_reset) begin
          state_next = DUM_RESET;
        end else if (cnt_reg >= 16'(CLEAR_CYCLES - 1)) begin
          state_next = DUM_IDLE;
        end
      end
      DUM_RESET: begin
        if (cnt_reg >= 16'(RESET_CYCLES - 1)) begin
          state_next = DUM_IDLE;
        end
      end
      default: state_next = DUM_RESET;
    endcase
  end

  // Busy falls on any non-idle state and rises on return to idle.
  wire busy_rise = state_reg != DUM_IDLE && state_next == DUM_IDLE;
  // Stored or fresh strobe applied when not busy.
  // Tied-low strobe fires on every busy rise.
  wire apply_now = state_next == DUM_IDLE &&
                   ((state_reg == DUM_IDLE && (strobe_fall ||
                   strobe_pend_reg)) || (busy_rise && (strobe_pend_reg ||
                   strobe_low || strobe_fall)));

  // Sequencer, counters, pending strobe and dirty flags.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Power-on reset runs the reset sequence with busy low.
      state_reg <= DUM_RESET;
      cnt_reg <= 16'h0000;
      strobe_pend_reg <= 1'b0;
      dirty_reg <= '0;
      clr_code_reg <= DATA_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;
      if (is_clrc) begin
        clr_code_reg <= cmd_data_i;
      end
      if (state_reg == DUM_RESET) begin
        strobe_pend_reg <= 1'b0;
        clr_code_reg <= DATA_RST;
        dirty_reg <= '0;
      end else if (apply_now) begin
        strobe_pend_reg <= 1'b0;
      end else if (strobe_fall) begin
        strobe_pend_reg <= 1'b1;
      end
      if (state_reg != DUM_RESET && apply_now) begin
        dirty_reg <= '0;
      end
      if (calc_we && state_reg != DUM_RESET) begin
        dirty_reg[calc_ch_reg] <= 1'b1;
      end
    end
  end

  // Calculation engine: walks the pending channels, one read cycle and
  // one store cycle each, so back-to-back writes are never lost.
  // Write triggers recompute with busy low.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch_reg <= 6'h00;
      calc_ch_reg <= 6'h00;
      calc_ph_reg <= 1'b0;
      calc_we <= 1'b0;
      pend_reg <= '0;
    end else begin
      calc_we <= 1'b0;
      if (state_reg == DUM_RESET) begin
        // Reset discards any pending work.
        pend_reg <= '0;
        calc_ph_reg <= 1'b0;
      end else if (state_reg == DUM_CALC) begin
        if (calc_ph_reg) begin
          // Store cycle: read data for this channel is now valid.
          calc_we <= 1'b1;
          calc_ch_reg <= ch_reg;
          pend_reg[ch_reg] <= 1'b0;
          calc_ph_reg <= 1'b0;
          ch_reg <= ch_next;
        end else if (pend_reg[ch_reg]) begin
          // Read cycle: raw word is fetched at this edge.
          calc_ph_reg <= 1'b1;
        end else begin
          // Nothing to do here, move on.
          ch_reg <= ch_next;
        end
      end
      // New writes accepted during calculation; the set wins
      // over a clear of the same channel, forcing a recompute.
      if (is_wr) begin
        pend_reg[cmd_addr_i] <= 1'b1;
      end
    end
  end

  // DAC register update scan: strobe walks dirty channels, clear and
  // reset walk all channels.
  logic scan_reg;
  logic [5:0] scan_ch_reg;
  logic [NUM_CH-1:0] scan_mask_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_reg <= 1'b0;
      scan_ch_reg <= 6'h00;
      scan_mask_reg <= '0;
      dac_we_o <= 1'b0;
      dac_ch_o <= 6'h00;
      dac_word_o <= DATA_RST;
    end else begin
      dac_we_o <= 1'b0;
      if (state_reg == DUM_RESET || state_reg == DUM_CLEAR) begin
        // Reset zeroes, clear loads clear code.
        // Full walk ends well within the clear time.
        scan_reg <= 1'b0;
        if (cnt_reg < 16'(NUM_CH)) begin
          dac_we_o <= 1'b1;
          dac_ch_o <= cnt_ch;
          dac_word_o <= state_reg == DUM_RESET ? DATA_RST : clr_code_reg;
        end
      end else if (apply_now && !scan_reg) begin
        // Only channels written since the last strobe.
        scan_reg <= 1'b1;
        scan_ch_reg <= 6'h00;
        scan_mask_reg <= dirty_reg;
      end else if (scan_reg && state_reg == DUM_IDLE) begin
        dac_we_o <= scan_mask_reg[scan_ch_reg];
        dac_ch_o <= scan_ch_reg;
        dac_word_o <= x2_q[scan_ch_reg];
        scan_ch_reg <= scan_ch_reg + 6'h01;
        if (scan_ch_reg == 6'(NUM_CH - 1)) begin
          scan_reg <= 1'b0;
        end
      end
    end
  end

  // Control word and probe selection.
  // Selection held until a new command, clear or reset.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_o <= CTRL_RST;
      probe_channel_o <= PROBE_RST;
    end else if (state_reg == DUM_RESET) begin
      ctrl_o <= CTRL_RST;
      probe_channel_o <= PROBE_RST;
    end else if (do_clear) begin
      probe_channel_o <= PROBE_RST;
    end else if (is_ctrl) begin
      ctrl_o <= cmd_data_i;
    end else if (is_mon && ctrl_o[PROBE_EN_POS]) begin
      probe_channel_o <= cmd_data_i[11:6];
    end
  end

  // Probe outputs and status flags.
  // Control bit enables probing.
  wire probe_en = ctrl_o[PROBE_EN_POS];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_b_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      probe_route_o <= 1'b0;
      probe_oe_o <= 1'b0;
      ch39_is_probe_o <= 1'b0;
    end else begin
      // Busy low for reset and all other work.
      busy_b_o <= state_next == DUM_IDLE;
      cmd_ready_o <= state_next != DUM_RESET;
      ch39_is_probe_o <= probe_en;
      // Routed only for channels 0 to 38.
      probe_route_o <= probe_en & (probe_channel_o <= PROBE_LAST_CH);
      probe_oe_o <= ~probe_en | (probe_channel_o != PROBE_OFF);
    end
  end
endmodule
`default_nettype wire

// >>> hw/dum_pkg.sv
// Shared constants and types for the DAC update and monitor control core.
`default_nettype none
package dum_pkg;
  // Clock rate in kilohertz; 50 MHz system clock.
  localparam int unsigned CLK_KHZ = 50000;
  // Reset sequence length in microseconds.
  localparam int unsigned RESET_US = 270;
  // Clear execution time in microseconds (a longest time, rounded down).
  localparam int unsigned CLEAR_US = 35;
  // Cycle counts derived from the times above.
  localparam int unsigned RESET_CYC = RESET_US * (CLK_KHZ / 1000);
  localparam int unsigned CLEAR_CYC = CLEAR_US * (CLK_KHZ / 1000);
  // Number of analog channels and data width.
  localparam int unsigned NUM_CH = 40;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned CH_W = 6;
  // Register select codes.
  localparam logic [1:0] SEL_SFR = 2'h0;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_OFFS = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  // Special function addresses.
  localparam logic [5:0] SFR_NOP = 6'h00;
  localparam logic [5:0] SFR_CLR_CODE = 6'h01;
  localparam logic [5:0] SFR_SOFT_CLR = 6'h02;
  localparam logic [5:0] SFR_CTRL = 6'h0C;
  localparam logic [5:0] SFR_MONITOR = 6'h0A;
  localparam logic [5:0] SFR_SOFT_RST = 6'h0F;
  // Probe enable bit position in the control word.
  localparam int unsigned PROBE_EN_POS = 7;
  // Highest routable channel and the three-state address.
  localparam logic [5:0] PROBE_LAST_CH = 6'h26;
  localparam logic [5:0] PROBE_OFF = 6'h3F;
  // Reset values.
  localparam logic [11:0] GAIN_RST = 12'hFFE;
  localparam logic [11:0] OFFS_RST = 12'h800;
  localparam logic [11:0] DATA_RST = 12'h000;
  localparam logic [11:0] CTRL_RST = 12'h800;
  localparam logic [5:0] PROBE_RST = 6'h3F;
  // Minimum cycle count in the calculation state before it may return to idle.
  localparam int unsigned CALC_CYC = 4;
  // Sequencer states, Gray coded along idle-calc-idle.
  typedef enum logic [1:0] {
    DUM_IDLE = 2'b00,
    DUM_CALC = 2'b01,
    DUM_CLEAR = 2'b11,
    DUM_RESET = 2'b10
  } dum_state_t;
endpackage
`default_nettype wire

// >>> hw/dum_word_mem.sv
// Small per-channel word memory with registered read data.
`default_nettype none
module dum_word_mem #(
  parameter int unsigned DEPTH = 40,
  parameter int unsigned WIDTH = 12,
  parameter int unsigned AW = 6
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  // Storage array; contents are defined by the owner through writes.
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Write port and registered read port.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end
endmodule
`default_nettype wire

// >>> bench/dum_core_checker.sv
// Concurrent checks on the control core ports.
`default_nettype none
module dum_core_checker
  import dum_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_CYC,
  parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic register_select_hi_i,
  input wire logic register_select_lo_i,
  input wire logic [5:0] cmd_addr_i,
  input wire logic busy_b_o,
  input wire logic cmd_ready_o,
  input wire logic dac_we_o,
  input wire logic [5:0] dac_ch_o,
  input wire logic [11:0] dac_word_o,
  input wire logic probe_route_o,
  input wire logic [5:0] probe_channel_o,
  input wire logic probe_oe_o,
  input wire logic ch39_is_probe_o,
  input wire logic [11:0] ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Longest legal busy run; a stuck sequencer overruns it.
  localparam int unsigned LONGEST =
    (RESET_CYCLES > CLEAR_CYCLES) ? RESET_CYCLES : CLEAR_CYCLES;
  // Length of the current busy-low run.
  logic [15:0] low_cnt_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= busy_b_o ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
  end
  // Accepted channel write, which must start a calculation.
  wire logic chan_wr = cmd_valid_i && cmd_ready_o && cmd_addr_i < 6'h28
    && (register_select_hi_i || register_select_lo_i);
  // Start of a reset sequence: busy and ready held low.
  sequence s_held_off;
    (!busy_b_o && !cmd_ready_o) [*8];
  endsequence
  a_reset_holds: assert property (
    $rose(rst_b_i) |-> s_held_off) else $error("reset busy short");
  a_write_busy: assert property (
    chan_wr |=> !busy_b_o) else $error("write did not raise busy");
  a_reset_zeroes: assert property (
    dac_we_o && !cmd_ready_o |-> dac_word_o == DATA_RST
    && dac_ch_o < 6'h28) else $error("reset wrote nonzero word");
  a_busy_bounded: assert property (
    low_cnt_reg <= LONGEST + 8) else $error("busy low too long");
  a_probe_tri: assert property (
    ch39_is_probe_o && probe_channel_o == PROBE_OFF
    && $stable(probe_channel_o) |-> !probe_oe_o
    && !probe_route_o) else $error("probe driven at address 63");
  a_probe_gate: assert property (
    !ctrl_o[PROBE_EN_POS] && !$past(ctrl_o[PROBE_EN_POS]) |->
    !ch39_is_probe_o && !probe_route_o) else $error("probe while off");
  a_route_range: assert property (
    probe_route_o |-> $past(probe_channel_o) <= PROBE_LAST_CH
    && ch39_is_probe_o)
    else $error("route outside channel range");
  a_sel_hold: assert property (
    !$stable(probe_channel_o) |-> $past(cmd_valid_i) ||
    $past(cmd_valid_i, 2) || !busy_b_o || !$past(busy_b_o))
    else $error("probe selection changed unasked");
endmodule
bind dum_core dum_core_checker #(
  .RESET_CYCLES(RESET_CYCLES),
  .CLEAR_CYCLES(CLEAR_CYCLES)
) u_chk (.clk_i, .rst_b_i, .cmd_valid_i, .register_select_hi_i,
  .register_select_lo_i, .cmd_addr_i, .busy_b_o, .cmd_ready_o, .dac_we_o,
  .dac_ch_o, .dac_word_o, .probe_route_o, .probe_channel_o, .probe_oe_o,
  .ch39_is_probe_o, .ctrl_o);
`default_nettype wire

// >>> bench/dum_host.sv
// Host controller model driving the command port and control pins.
`default_nettype none
module dum_host (
  input wire logic clk_i,
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic sel_hi_o,
  output logic sel_lo_o,
  output logic [5:0] cmd_addr_o,
  output logic [11:0] cmd_data_o,
  output logic reset_pin_b_o,
  output logic clear_pin_b_o,
  output logic load_strobe_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins high, command port quiet.
  initial begin
    cmd_valid_o = 1'b0;
    {sel_hi_o, sel_lo_o} = 2'h0;
    cmd_addr_o = 6'h00;
    cmd_data_o = 12'h000;
    {reset_pin_b_o, clear_pin_b_o, load_strobe_b_o} = 3'h7;
  end
  task automatic send(input logic [1:0] sel, input logic [5:0] a,
                      input logic [11:0] d);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    {sel_hi_o, sel_lo_o} <= sel;
    cmd_addr_o <= a;
    cmd_data_o <= d;
    do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
    // Released fields carry junk, not the last value.
    cmd_valid_o <= 1'b0;
    {sel_hi_o, sel_lo_o} <= ~sel;
    cmd_addr_o <= ~a;
    cmd_data_o <= ~d;
  endtask
  // strobe may be held low for good
  task automatic pins(input logic r, input logic c, input logic l);
    @(posedge clk_i);
    {reset_pin_b_o, clear_pin_b_o, load_strobe_b_o} <= {r, c, l};
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench for the control core.
`default_nettype none
module testbench
  import dum_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RST_N = 60;
  localparam int unsigned CLR_N = 50;
  logic clk_i, rst_b_i, rp_b, cp_b, ls_b, vld, shi, slo;
  logic [5:0] addr, dac_ch_o, probe_channel_o;
  logic [11:0] data, dac_word_o, ctrl_o;
  logic busy_b_o, cmd_ready_o, dac_we_o, probe_route_o, probe_oe_o, c39;
  logic [11:0] img [40];
  int wr_cnt, bad_count, compares, n, w0;
  logic [5:0] last_ch;
  logic [5:0] mon_ch [3] = '{6'h00, 6'h15, 6'h26};
  dum_host u_host (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o),
    .cmd_valid_o(vld), .sel_hi_o(shi), .sel_lo_o(slo), .cmd_addr_o(addr),
    .cmd_data_o(data), .reset_pin_b_o(rp_b), .clear_pin_b_o(cp_b),
    .load_strobe_b_o(ls_b));
  dum_core #(.RESET_CYCLES(RST_N), .CLEAR_CYCLES(CLR_N)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reset_pin_b_i(rp_b),
    .clear_pin_b_i(cp_b), .load_strobe_b_i(ls_b), .cmd_valid_i(vld),
    .register_select_hi_i(shi), .register_select_lo_i(slo),
    .cmd_addr_i(addr), .cmd_data_i(data), .busy_b_o(busy_b_o),
    .cmd_ready_o(cmd_ready_o), .dac_we_o(dac_we_o), .dac_ch_o(dac_ch_o),
    .dac_word_o(dac_word_o), .probe_route_o(probe_route_o),
    .probe_channel_o(probe_channel_o), .probe_oe_o(probe_oe_o),
    .ch39_is_probe_o(c39), .ctrl_o(ctrl_o));
  // Clock of 20 ns period.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Image of the DAC registers built from the write pulses.
  always @(posedge clk_i) begin
    if (dac_we_o === 1'b1) begin
      wr_cnt++;
      last_ch = dac_ch_o;
      if (dac_ch_o < 6'h28) img[dac_ch_o] = dac_word_o;
    end
  end
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // Wait for busy to fall, then count its low cycles.
  task automatic run_len(output int k);
    k = 0;
    for (int i = 0; i < 20 && busy_b_o !== 1'b0; i++) @(posedge clk_i);
    while (busy_b_o !== 1'b1 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  // Wait for idle, then let the update scan finish.
  task automatic settle();
    repeat (3) @(posedge clk_i);
    run_len(n);
    check(n < 500, "busy stuck low");
    repeat (60) @(posedge clk_i);
  endtask
  task automatic img_is(input logic [11:0] v);
    for (int i = 0; i < 40; i++) check(img[i] === v, "dac image");
  endtask
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog far beyond the planned run.
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    rst_b_i = 1'b0;
    wr_cnt = 0;
    bad_count = 0;
    compares = 0;
    for (int i = 0; i < 40; i++) img[i] = 12'hFFF;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    run_len(n);
    check(n >= RST_N - 2 && n <= RST_N + 6, "power-on busy");
    repeat (5) @(posedge clk_i);
    img_is(DATA_RST);
    check(ctrl_o === CTRL_RST && c39 === 1'b0, "ctrl default");
    // Strobe during calculation is kept and only dirty channel updates.
    w0 = wr_cnt;
    u_host.send(SEL_DATA, 6'h03, 12'h123);
    u_host.pins(1'b1, 1'b1, 1'b0);
    u_host.pins(1'b1, 1'b1, 1'b1);
    check(busy_b_o === 1'b0 && wr_cnt == w0, "update in busy");
    settle();
    check(wr_cnt == w0 + 1 && last_ch === 6'h03, "stored strobe");
    w0 = wr_cnt;
    u_host.pins(1'b1, 1'b1, 1'b0);
    u_host.pins(1'b1, 1'b1, 1'b1);
    settle();
    check(wr_cnt == w0, "clean channels rewritten");
    // Strobe tied low, back-to-back writes.
    u_host.pins(1'b1, 1'b1, 1'b0);
    w0 = wr_cnt;
    u_host.send(SEL_GAIN, 6'h07, 12'h400);
    u_host.send(SEL_OFFS, 6'h09, 12'h7F0);
    settle();
    check(wr_cnt == w0 + 2, "tied strobe updates");
    u_host.pins(1'b1, 1'b1, 1'b1);
    // Monitor select while disabled, then enabled.
    u_host.send(SEL_SFR, SFR_MONITOR, 12'h140);
    repeat (4) @(posedge clk_i);
    check(probe_route_o === 1'b0 && c39 === 1'b0, "disabled probe");
    u_host.send(SEL_SFR, SFR_CTRL, CTRL_RST | 12'h080);
    for (int i = 0; i < 3; i++) begin
      u_host.send(SEL_SFR, SFR_MONITOR, {mon_ch[i], 6'h2A});
      repeat (4) @(posedge clk_i);
      check(probe_channel_o === mon_ch[i] && probe_route_o === 1'b1
            && probe_oe_o === 1'b1 && c39 === 1'b1, "route");
    end
    u_host.send(SEL_SFR, SFR_MONITOR, 12'hFC0);
    repeat (4) @(posedge clk_i);
    check(probe_oe_o === 1'b0, "probe not off");
    u_host.send(SEL_GAIN, SFR_MONITOR, 12'h080);
    settle();
    check(probe_channel_o === PROBE_OFF, "non-SFR decoded");
    // Clear by pin, then by command.
    for (int s = 0; s < 2; s++) begin
      u_host.send(SEL_SFR, SFR_CLR_CODE, 12'h5A5 ^ s[11:0]);
      settle();
      if (s == 0) u_host.pins(1'b1, 1'b0, 1'b1);
      else u_host.send(SEL_SFR, SFR_SOFT_CLR, 12'h000);
      run_len(n);
      check(n > 0 && n <= CLR_N + 2, "clear time");
      u_host.pins(1'b1, 1'b1, 1'b1);
      settle();
      img_is(12'h5A5 ^ s[11:0]);
    end
    // Reset pin held low: one reset, strobe ignored.
    u_host.pins(1'b0, 1'b1, 1'b1);
    repeat (10) @(posedge clk_i);
    check(cmd_ready_o === 1'b0, "ready in reset");
    u_host.pins(1'b0, 1'b1, 1'b0);
    u_host.pins(1'b0, 1'b1, 1'b1);
    run_len(n);
    check(n >= RST_N - 12 && n <= RST_N + 6, "pin reset busy");
    repeat (100) @(posedge clk_i);
    check(busy_b_o === 1'b1 && ctrl_o === CTRL_RST, "reset repeat");
    img_is(DATA_RST);
    u_host.pins(1'b1, 1'b1, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
